// *** rtl/dmas_pkg.sv ***
package dmas_pkg;
    localparam int unsigned DMAS_AW = 8;
    localparam int unsigned DMAS_DW = 32;

    localparam logic [7:0] DMAS_RX_BASE_OFF = 8'h18;
    localparam logic [7:0] DMAS_TX_BASE_OFF = 8'h20;
    localparam logic [7:0] DMAS_STATUS_OFF = 8'h28;
    localparam logic [7:0] DMAS_IRQ_EN_OFF = 8'h38;

    // base registers keep bits 31..2, bits 1..0 always read zero
    localparam int unsigned DMAS_ALIGN_W = 2;
    localparam logic [1:0] DMAS_ALIGN_ZERO = 2'h0;
    localparam logic [29:0] DMAS_BASE_RST = 30'h0;

    // sticky event bits of the status word, bits 16..0
    localparam int unsigned DMAS_EVW = 17;
    localparam int unsigned DMAS_TX_DONE_BIT = 0;
    localparam int unsigned DMAS_TX_HALT_BIT = 1;
    localparam int unsigned DMAS_TX_DESC_MISS_BIT = 2;
    localparam int unsigned DMAS_TX_JABBER_BIT = 3;
    localparam int unsigned DMAS_TX_UFLOW_BIT = 5;
    localparam int unsigned DMAS_RX_DONE_BIT = 6;
    localparam int unsigned DMAS_RX_DESC_MISS_BIT = 7;
    localparam int unsigned DMAS_RX_HALT_BIT = 8;
    localparam int unsigned DMAS_RX_WDOG_BIT = 9;
    localparam int unsigned DMAS_GTIMER_BIT = 11;
    localparam int unsigned DMAS_FATAL_BIT = 13;
    localparam int unsigned DMAS_ABN_SUM_BIT = 15;
    localparam int unsigned DMAS_NORM_SUM_BIT = 16;

    localparam logic [16:0] DMAS_NORM_SRC_MASK = 17'h00045;
    localparam logic [16:0] DMAS_ABN_SRC_MASK = 17'h02baa;
    localparam logic [16:0] DMAS_STATUS_DEFINED = 17'h1abef;
    localparam logic [16:0] DMAS_STATUS_RST = 17'h0;
    localparam logic [16:0] DMAS_IRQ_EN_RST = 17'h0;

    localparam int unsigned DMAS_RX_STATE_LSB = 17;
    localparam int unsigned DMAS_TX_STATE_LSB = 20;
    localparam int unsigned DMAS_FAULT_KIND_LSB = 23;
    localparam int unsigned DMAS_PSTATE_W = 3;

    localparam logic [2:0] DMAS_TX_STOP = 3'h0;
    localparam logic [2:0] DMAS_TX_READ_DESC = 3'h1;
    localparam logic [2:0] DMAS_TX_SENDING = 3'h2;
    localparam logic [2:0] DMAS_TX_FIFO_FILL = 3'h3;
    localparam logic [2:0] DMAS_TX_SUSPENDED = 3'h6;
    localparam logic [2:0] DMAS_TX_WRITE_DESC = 3'h7;

    localparam logic [2:0] DMAS_RX_STOP = 3'h0;
    localparam logic [2:0] DMAS_RX_READ_DESC = 3'h1;
    localparam logic [2:0] DMAS_RX_CHECK = 3'h2;
    localparam logic [2:0] DMAS_RX_WAIT_DATA = 3'h3;
    localparam logic [2:0] DMAS_RX_SUSPENDED = 3'h4;
    localparam logic [2:0] DMAS_RX_WRITE_DESC = 3'h5;
    localparam logic [2:0] DMAS_RX_FLUSH = 3'h6;
    localparam logic [2:0] DMAS_RX_DRAIN = 3'h7;

    typedef enum logic [2:0] {
        DMAS_FAULT_PARITY = 3'h0,
        DMAS_FAULT_MASTER_ABORT = 3'h1,
        DMAS_FAULT_TARGET_ABORT = 3'h2
    } dmas_fault_kind_t;

    typedef enum logic {
        DMAS_BUS_ACTIVE = 1'b0,
        DMAS_BUS_HALTED = 1'b1
    } dmas_bus_t;
endpackage

// *** rtl/dmas_sticky_bits.sv ***
module dmas_sticky_bits (
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic [dmas_pkg::DMAS_EVW-1:0] i_set,
    input wire logic [dmas_pkg::DMAS_EVW-1:0] i_clear,
    output logic [dmas_pkg::DMAS_EVW-1:0] o_bits
);
    import dmas_pkg::*;

    typedef struct packed {
        logic [DMAS_EVW-1:0] bits;
    } dmas_sticky_state_t;

    dmas_sticky_state_t state_reg;
    dmas_sticky_state_t state_next;
    logic [DMAS_EVW-1:0] bit_next;

    // a set in the same cycle as its clear wins, so no event is lost
    for (genvar g = 0; g < DMAS_EVW; g++) begin : g_bit
        assign bit_next[g] = i_set[g] | (state_reg.bits[g] & ~i_clear[g]);
    end

    always_comb begin
        state_next = state_reg;
        state_next.bits = bit_next & DMAS_STATUS_DEFINED;
    end

    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            state_reg <= '{bits: DMAS_STATUS_RST};
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_bits = state_reg.bits;
endmodule

// *** rtl/dmas_top.sv ***
// Contract
// - rx base bits 31..2 writable, 1..0 zero
// - tx base bits 31..2 writable, 1..0 zero
// - fault kind: parity, master, target abort
// - fault kind never interrupts by itself
// - transmit state field reported read-only
// - receive state field reported read-only
// - normal summary from bits 0, 2, 6
// - abnormal summary from eight abnormal bits
// - bus fault sets flag, records kind, halts
// - general timer expiry sets bit 11
// - receive watchdog expiry sets bit 9
// - receive entering stop sets bit 8
// - bit 1 set while transmit is stopped
// - underflow sets bit 5, transmit suspends
module dmas_top (
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic [dmas_pkg::DMAS_AW-1:0] i_addr,
    input wire logic [dmas_pkg::DMAS_DW-1:0] i_wr_data,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [dmas_pkg::DMAS_PSTATE_W-1:0] i_tx_state,
    input wire logic [dmas_pkg::DMAS_PSTATE_W-1:0] i_rx_state,
    input wire logic i_tx_frame_done,
    input wire logic i_tx_descriptor_missing,
    input wire logic i_tx_jabber_expired,
    input wire logic i_tx_fifo_underflow,
    input wire logic i_rx_frame_done,
    input wire logic i_rx_descriptor_missing,
    input wire logic i_rx_watchdog_expired,
    input wire logic i_general_timer_expired,
    input wire logic i_parity_error,
    input wire logic i_master_abort,
    input wire logic i_target_abort,
    output logic [dmas_pkg::DMAS_DW-1:0] o_rd_data,
    output logic o_irq,
    output logic [dmas_pkg::DMAS_DW-1:0] o_rx_ring_start,
    output logic [dmas_pkg::DMAS_DW-1:0] o_tx_ring_start,
    output logic o_bus_master_enable,
    output logic o_tx_suspend
);
    import dmas_pkg::*;

    typedef struct packed {
        logic [29:0] rx_ring_start;
        logic [29:0] tx_ring_start;
        logic [DMAS_EVW-1:0] irq_en;
        dmas_fault_kind_t bus_fault_kind;
        dmas_bus_t bus;
        logic bus_en;
        logic [DMAS_PSTATE_W-1:0] rx_state_prev;
        logic [DMAS_DW-1:0] rd_data;
        logic irq;
        logic tx_suspend;
    } dmas_top_state_t;

    localparam dmas_top_state_t DMAS_TOP_RST = '{
        rx_ring_start: DMAS_BASE_RST,
        tx_ring_start: DMAS_BASE_RST,
        irq_en: DMAS_IRQ_EN_RST,
        bus_fault_kind: DMAS_FAULT_PARITY,
        bus: DMAS_BUS_ACTIVE,
        bus_en: 1'b1,
        rx_state_prev: DMAS_RX_STOP,
        rd_data: '0,
        irq: 1'b0,
        tx_suspend: 1'b0
    };

    dmas_top_state_t state_reg;
    dmas_top_state_t state_next;

    logic [DMAS_EVW-1:0] status_bits;
    logic [DMAS_EVW-1:0] ev_set;
    logic [DMAS_EVW-1:0] ev_clear;
    logic [DMAS_EVW-1:0] status_after;
    logic fault_now;
    logic rx_entered_stop;
    logic [DMAS_DW-1:0] status_word;

    dmas_sticky_bits u_status (
        .i_clock(i_clock),
        .i_rstn(i_rstn),
        .i_set(ev_set),
        .i_clear(ev_clear),
        .o_bits(status_bits)
    );

    // a fault is only taken while the bus is still ours; later ones keep the first kind
    assign fault_now = (i_parity_error | i_master_abort | i_target_abort)
                       && (state_reg.bus == DMAS_BUS_ACTIVE);

    // edge, not level: the receive halt flag must not refire after a clear while stopped
    assign rx_entered_stop = (i_rx_state == DMAS_RX_STOP)
                             && (state_reg.rx_state_prev != DMAS_RX_STOP);

    always_comb begin
        status_word = '0;
        status_word[DMAS_EVW-1:0] = status_bits & DMAS_STATUS_DEFINED;
        status_word[DMAS_RX_STATE_LSB +: DMAS_PSTATE_W] = i_rx_state;
        status_word[DMAS_TX_STATE_LSB +: DMAS_PSTATE_W] = i_tx_state;
        status_word[DMAS_FAULT_KIND_LSB +: DMAS_PSTATE_W] = state_reg.bus_fault_kind;
    end

    always_comb begin
        state_next = state_reg;
        ev_set = '0;
        ev_clear = '0;
        status_after = '0;

        ev_set[DMAS_TX_DONE_BIT] = i_tx_frame_done;
        ev_set[DMAS_TX_HALT_BIT] = (i_tx_state == DMAS_TX_STOP);
        ev_set[DMAS_TX_DESC_MISS_BIT] = i_tx_descriptor_missing;
        ev_set[DMAS_TX_JABBER_BIT] = i_tx_jabber_expired;
        ev_set[DMAS_TX_UFLOW_BIT] = i_tx_fifo_underflow;
        ev_set[DMAS_RX_DONE_BIT] = i_rx_frame_done;
        ev_set[DMAS_RX_DESC_MISS_BIT] = i_rx_descriptor_missing;
        ev_set[DMAS_RX_HALT_BIT] = rx_entered_stop;
        ev_set[DMAS_RX_WDOG_BIT] = i_rx_watchdog_expired;
        ev_set[DMAS_GTIMER_BIT] = i_general_timer_expired;
        ev_set[DMAS_FATAL_BIT] = fault_now;

        if (i_wr) begin
            case (i_addr)
                DMAS_RX_BASE_OFF: begin
                    state_next.rx_ring_start = i_wr_data[DMAS_DW-1:DMAS_ALIGN_W];
                end
                DMAS_TX_BASE_OFF: begin
                    state_next.tx_ring_start = i_wr_data[DMAS_DW-1:DMAS_ALIGN_W];
                end
                DMAS_STATUS_OFF: begin
                    // state and fault kind fields ignore writes
                    ev_clear = i_wr_data[DMAS_EVW-1:0] & DMAS_STATUS_DEFINED;
                end
                DMAS_IRQ_EN_OFF: begin
                    state_next.irq_en = i_wr_data[DMAS_EVW-1:0] & DMAS_STATUS_DEFINED;
                end
                default: begin
                end
            endcase
        end

        // summaries follow sources that stay set after this cycle's clear
        status_after = (status_bits & ~ev_clear) | ev_set;
        ev_set[DMAS_NORM_SUM_BIT] = |(status_after & DMAS_NORM_SRC_MASK);
        ev_set[DMAS_ABN_SUM_BIT] = |(status_after & DMAS_ABN_SRC_MASK);
        status_after = ((status_bits & ~ev_clear) | ev_set) & DMAS_STATUS_DEFINED;

        unique case (state_reg.bus)
            DMAS_BUS_ACTIVE: begin
                if (fault_now) begin
                    state_next.bus = DMAS_BUS_HALTED;
                    state_next.bus_en = 1'b0;
                    if (i_parity_error) begin
                        state_next.bus_fault_kind = DMAS_FAULT_PARITY;
                    end else if (i_master_abort) begin
                        state_next.bus_fault_kind = DMAS_FAULT_MASTER_ABORT;
                    end else begin
                        state_next.bus_fault_kind = DMAS_FAULT_TARGET_ABORT;
                    end
                end
            end
            DMAS_BUS_HALTED: begin
                // only reset gives the bus back, whatever software clears
                state_next.bus_en = 1'b0;
            end
        endcase

        state_next.rx_state_prev = i_rx_state;
        state_next.tx_suspend = i_tx_fifo_underflow;

        // fault kind is kept out of the status bits, so it never reaches the interrupt
        state_next.irq = |(status_after & state_next.irq_en);

        state_next.rd_data = '0;
        if (i_rd) begin
            case (i_addr)
                DMAS_RX_BASE_OFF: begin
                    state_next.rd_data = {state_reg.rx_ring_start, DMAS_ALIGN_ZERO};
                end
                DMAS_TX_BASE_OFF: begin
                    state_next.rd_data = {state_reg.tx_ring_start, DMAS_ALIGN_ZERO};
                end
                DMAS_STATUS_OFF: begin
                    state_next.rd_data = status_word;
                end
                DMAS_IRQ_EN_OFF: begin
                    state_next.rd_data[DMAS_EVW-1:0] = state_reg.irq_en;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            state_reg <= DMAS_TOP_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_rd_data = state_reg.rd_data;
    assign o_irq = state_reg.irq;
    assign o_rx_ring_start = {state_reg.rx_ring_start, DMAS_ALIGN_ZERO};
    assign o_tx_ring_start = {state_reg.tx_ring_start, DMAS_ALIGN_ZERO};
    assign o_bus_master_enable = state_reg.bus_en;
    assign o_tx_suspend = state_reg.tx_suspend;
endmodule

// *** tb/dmas_bus_model.sv ***
module dmas_bus_model (
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic [1:0] i_req,
    output logic o_parity_error,
    output logic o_master_abort,
    output logic o_target_abort
);
    timeunit 1ns;
    timeprecision 1ps;
    // faults are reported even when the engine is halted, so refusal stays visible
    always_ff @(posedge i_clock) begin
        o_parity_error <= i_rstn && i_req == 2'h1;
        o_master_abort <= i_rstn && i_req == 2'h2;
        o_target_abort <= i_rstn && i_req == 2'h3;
    end
endmodule

// *** tb/dmas_top_sva.sv ***
module dmas_top_sva (
    input wire logic i_clock, i_rstn, i_wr, i_rd, i_tx_fifo_underflow,
    input wire logic i_parity_error, i_master_abort, i_target_abort,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wr_data,
    input wire logic [2:0] i_tx_state, i_rx_state,
    input wire logic [31:0] o_rd_data, o_rx_ring_start, o_tx_ring_start,
    input wire logic o_bus_master_enable, o_tx_suspend
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rstn);
    a_rx_align_zero: assert property (o_rx_ring_start[1:0] == 2'h0) else $error("rx base low bits set");
    a_tx_align_zero: assert property (o_tx_ring_start[1:0] == 2'h0) else $error("tx base low bits set");
    a_rx_base_write: assert property (i_wr && i_addr == 8'h18 |=>
        o_rx_ring_start[31:2] == $past(i_wr_data[31:2])) else $error("rx base not written");
    a_tx_base_write: assert property (i_wr && i_addr == 8'h20 |=>
        o_tx_ring_start[31:2] == $past(i_wr_data[31:2])) else $error("tx base not written");
    a_fault_halts_bus: assert property ((i_parity_error || i_master_abort || i_target_abort) |=>
        !o_bus_master_enable) else $error("bus still enabled after fault");
    a_halt_stays: assert property (!o_bus_master_enable |=> !o_bus_master_enable) else $error("bus re-enabled");
    a_uflow_suspend: assert property (i_tx_fifo_underflow |=> o_tx_suspend ##1 !o_tx_suspend ||
        $past(i_tx_fifo_underflow)) else $error("no suspend pulse");
    a_suspend_cause: assert property (o_tx_suspend |-> $past(i_tx_fifo_underflow)) else $error("stray suspend");
    a_state_fields: assert property (i_rd && i_addr == 8'h28 |=>
        o_rd_data[22:17] == {$past(i_tx_state), $past(i_rx_state)}) else $error("state fields wrong");
    a_status_top_zero: assert property (i_rd && i_addr == 8'h28 |=> o_rd_data[31:26] == 6'h0)
        else $error("reserved status bits set");
endmodule
bind dmas_top dmas_top_sva u_sva (.*);

// *** tb/dmas_top_tb.sv ***
`define CHK(n, e, v) begin total_checks++; if ((v) !== (e)) begin bad_count++; \
    $display("wrong value %s expected %h seen %h", n, e, v); end end
module dmas_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dmas_pkg::*;
    logic i_clock = 1'b0, i_rstn = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
    logic [7:0] i_addr = 8'h0, ev = 8'h0;
    logic [31:0] i_wr_data = 32'h0, o_rd_data, o_rx_ring_start, o_tx_ring_start;
    logic [2:0] i_tx_state = 3'h0, i_rx_state = 3'h0;
    logic [1:0] f_req = 2'h0;
    logic o_irq, o_bus_master_enable, o_tx_suspend, i_parity_error, i_master_abort, i_target_abort;
    logic i_tx_frame_done, i_tx_descriptor_missing, i_tx_jabber_expired, i_tx_fifo_underflow;
    logic i_rx_frame_done, i_rx_descriptor_missing, i_rx_watchdog_expired, i_general_timer_expired;
    int bad_count = 0, total_checks = 0;
    localparam logic [31:0] ST = 32'h00260000;
    assign {i_general_timer_expired, i_rx_watchdog_expired, i_rx_descriptor_missing, i_rx_frame_done,
        i_tx_fifo_underflow, i_tx_jabber_expired, i_tx_descriptor_missing, i_tx_frame_done} = ev;
    dmas_top dut (.*);
    dmas_bus_model u_bus (.i_clock(i_clock), .i_rstn(i_rstn), .i_req(f_req), .o_parity_error(i_parity_error),
        .o_master_abort(i_master_abort), .o_target_abort(i_target_abort));
    initial begin
        forever #12.5 i_clock = ~i_clock;
    end
    task automatic step(int n);
        repeat (n) @(posedge i_clock);
    endtask
    task automatic rst;
        @(posedge i_clock);
        i_rstn <= 1'b0;
        step(12);
        i_rstn <= 1'b1;
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge i_clock);
        i_wr <= 1'b1; i_addr <= a; i_wr_data <= d;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask
    task automatic rdc(logic [7:0] a, logic [31:0] e, string n);
        @(posedge i_clock);
        i_rd <= 1'b1; i_addr <= a;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1 `CHK(n, e, o_rd_data)
    endtask
    task automatic states(logic [2:0] t, logic [2:0] r);
        @(posedge i_clock);
        i_tx_state <= t; i_rx_state <= r;
    endtask
    task automatic t_regs;
        rdc(DMAS_RX_BASE_OFF, 32'h0, "rx base reset");
        rdc(DMAS_TX_BASE_OFF, 32'h0, "tx base reset");
        wr(DMAS_RX_BASE_OFF, 32'hffffffff);
        wr(DMAS_TX_BASE_OFF, 32'h12345677);
        rdc(DMAS_RX_BASE_OFF, 32'hfffffffc, "rx base");
        rdc(DMAS_TX_BASE_OFF, 32'h12345674, "tx base");
        `CHK("tx ring port", 32'h12345674, o_tx_ring_start)
        `CHK("rx ring port", 32'hfffffffc, o_rx_ring_start)
        rdc(8'h04, 32'h0, "unmapped");
        rdc(DMAS_STATUS_OFF, 32'h8002, "tx stopped");
        $display("test regs done");
    endtask
    task automatic t_events;
        int b[8] = '{0, 2, 3, 5, 6, 7, 9, 11};
        logic [31:0] e;
        states(3'h2, 3'h3);
        wr(DMAS_STATUS_OFF, 32'h1ffff);
        rdc(DMAS_STATUS_OFF, ST, "cleared");
        for (int k = 0; k < 8; k++) begin
            e = ST | (32'h1 << b[k]) | ((b[k] inside {0, 2, 6}) ? 32'h10000 : 32'h8000);
            @(posedge i_clock);
            ev <= 8'h1 << k;
            @(posedge i_clock);
            ev <= 8'h0;
            #1 `CHK("suspend", (k == 3), o_tx_suspend)
            rdc(DMAS_STATUS_OFF, e, "event");
            rdc(DMAS_STATUS_OFF, e, "event held");
            wr(DMAS_STATUS_OFF, e & 32'h1ffff);
            rdc(DMAS_STATUS_OFF, ST, "event cleared");
        end
        wr(DMAS_IRQ_EN_OFF, 32'h1);
        ev <= 8'h1;
        @(posedge i_clock);
        ev <= 8'h0;
        #1 `CHK("irq", 1'b1, o_irq)
        wr(DMAS_STATUS_OFF, 32'h10001);
        #1 `CHK("irq cleared", 1'b0, o_irq)
        $display("test events done");
    endtask
    task automatic t_states;
        for (int s = 0; s < 8; s++) begin
            states(s[2:0], 3'h7 - s[2:0]);
            rdc(DMAS_STATUS_OFF, {9'h0, s[2:0], 3'h7 - s[2:0], (s == 7) ? 17'h08102 : 17'h08002},
                "settle");
            `CHK("states", {s[2:0], 3'h7 - s[2:0]}, o_rd_data[22:17])
        end
        states(3'h2, 3'h3);
        wr(DMAS_STATUS_OFF, 32'h1ffff);
        states(3'h2, 3'h0);
        rdc(DMAS_STATUS_OFF, 32'h00208100, "rx stopped");
        wr(DMAS_STATUS_OFF, 32'h8100);
        rdc(DMAS_STATUS_OFF, 32'h00200000, "rx stop once");
        states(3'h0, 3'h0);
        wr(DMAS_STATUS_OFF, 32'h8002);
        rdc(DMAS_STATUS_OFF, 32'h8002, "tx stop level");
        $display("test states done");
    endtask
    task automatic t_faults;
        for (int k = 0; k < 3; k++) begin
            states(3'h2, 3'h3);
            rst();
            @(posedge i_clock);
            f_req <= 2'(k + 1);
            @(posedge i_clock);
            f_req <= (k == 2) ? 2'h1 : 2'h3;
            @(posedge i_clock);
            f_req <= 2'h0;
            step(2);
            `CHK("bus enable", 1'b0, o_bus_master_enable)
            rdc(DMAS_STATUS_OFF, ST | (32'(k) << 23) | 32'ha000, "fault");
            wr(DMAS_STATUS_OFF, 32'ha000);
            wr(DMAS_IRQ_EN_OFF, 32'h1ffff);
            #1 `CHK("kind irq", 1'b0, o_irq)
        end
        $display("test faults done");
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        rst();
        t_regs();
        t_events();
        t_states();
        t_faults();
        end_of_test();
    end
    initial begin
        step(20000);
        bad_count++;
        end_of_test();
    end
endmodule
